/* File: design/bbs_defines.svh */
`ifndef BBS_DEFINES_SVH
`define BBS_DEFINES_SVH

// register indices
`define BBS_REG_CTRL 4'h0
`define BBS_REG_STAT 4'h1
`define BBS_REG_IRQ_STAT 4'h2
`define BBS_REG_IRQ_MASK 4'h3
`define BBS_REG_RAM_ADDR 4'h4
`define BBS_REG_RAM_DATA 4'h5

// control fields
`define BBS_CTRL_ARM 0
`define BBS_CTRL_WAKE_POL 1
`define BBS_CTRL_ARMED_EN 2
`define BBS_CTRL_RESET 8'h02

// status fields
`define BBS_STAT_STATE_LSB 0
`define BBS_STAT_ISO 4
`define BBS_STAT_WAKE 5
`define BBS_STAT_SWITCH 6
`define BBS_STAT_SUPPLY 7

// event bits
`define BBS_EV_ARMED 0
`define BBS_EV_SWITCH 1
`define BBS_EV_SAVED 2
`define BBS_EV_STANDBY 3
`define BBS_EV_NUM 4

// timing
`define BBS_CLK_PERIOD_NS 50
`define BBS_ISO_SETTLE_NS 200
`define BBS_ISO_SETTLE_CYC \
    ((`BBS_ISO_SETTLE_NS + `BBS_CLK_PERIOD_NS - 1) / `BBS_CLK_PERIOD_NS)

`endif

/* File: design/bbs_pkg.sv */
package bbs_pkg;
    typedef enum logic [2:0] {
        BBS_BOOT = 3'b000,
        BBS_ARM_ISO = 3'b001,
        BBS_IDLE = 3'b010,
        BBS_SAVE_ISO = 3'b011,
        BBS_SAVE = 3'b100,
        BBS_ISOLATE = 3'b101,
        BBS_DROP = 3'b110
    } bbs_state_e;
endpackage : bbs_pkg

/* File: design/bbs_ret_ram.sv */
`timescale 1ns/1ps
`include "bbs_defines.svh"

module bbs_ret_ram #(
    parameter int DEPTH = 16,
    parameter int AW = 4,
    parameter int DW = 8
) (
    // clock
    input wire logic sys_clk,
    // write
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [DW-1:0] wr_data,
    // read
    input wire logic [AW-1:0] rd_addr,
    output logic [DW-1:0] rd_data
);
    logic [DW-1:0] mem [DEPTH];

    genvar i;
    generate
        for (i = 0; i < DEPTH; i++) begin : g_ent
            always_ff @(posedge sys_clk) begin
                if (wr_en && wr_addr == AW'(i)) begin
                    mem[i] <= wr_data;
                end
            end
        end
    endgenerate

    always_ff @(posedge sys_clk) begin
        rd_data <= mem[rd_addr];
    end
endmodule : bbs_ret_ram

/* File: design/bbs_irq.sv */
`timescale 1ns/1ps
`include "bbs_defines.svh"

module bbs_irq #(
    parameter int N = `BBS_EV_NUM
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // events and software
    input wire logic [N-1:0] event_set,
    input wire logic stat_rd,
    input wire logic mask_wr,
    input wire logic [N-1:0] mask_data,
    // state
    output logic [N-1:0] irq_stat,
    output logic [N-1:0] irq_mask,
    output logic irq
);
    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_bit
            // set wins over the read clear
            always_ff @(posedge sys_clk or posedge rst) begin
                if (rst) begin
                    irq_stat[i] <= 1'b0;
                end else if (event_set[i]) begin
                    irq_stat[i] <= 1'b1;
                end else if (stat_rd) begin
                    irq_stat[i] <= 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            irq_mask <= '0;
        end else if (mask_wr) begin
            irq_mask <= mask_data;
        end
    end

    assign irq = |(irq_stat & irq_mask);
endmodule : bbs_irq

/* File: design/bbs_seq.sv */
// The implementer's own choices: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`include "bbs_defines.svh"

module bbs_seq
    import bbs_pkg::*;
#(
    parameter int AW = 4,
    parameter int DW = 8,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // power pins
    input wire logic power_switch_sense,
    output logic isolate_drive_port,
    output logic wake_out,
    output logic wake_oe,
    // interrupt
    output logic irq
);
    localparam int SETTLE = (`BBS_ISO_SETTLE_CYC < 1) ? 1 :
        `BBS_ISO_SETTLE_CYC;

    bbs_state_e state;
    bbs_state_e next_state;
    logic [7:0] ctrl;
    logic [3:0] settle_cnt;
    logic [AW-1:0] ram_addr;
    logic [DW-1:0] ram_rdata;
    logic ram_wr;
    logic ram_done;
    logic [`BBS_EV_NUM-1:0] ev;
    logic [`BBS_EV_NUM-1:0] irq_stat;
    logic [`BBS_EV_NUM-1:0] irq_mask;
    logic stat_rd;
    logic mask_wr;
    logic settled;
    logic wake_level;

    assign settled = (settle_cnt == 4'(SETTLE));

    // retention ram writes only while isolation is high
    assign ram_wr = reg_wr && reg_addr == `BBS_REG_RAM_DATA &&
        isolate_drive_port;

    // sequence steps
    always_comb begin
        next_state = state;
        case (state)
            BBS_BOOT: next_state = BBS_ARM_ISO;
            BBS_ARM_ISO: begin
                if (settled) begin
                    next_state = BBS_IDLE;
                end
            end
            BBS_IDLE: begin
                if (power_switch_sense && ctrl[`BBS_CTRL_ARM]) begin
                    next_state = BBS_SAVE_ISO;
                end
            end
            BBS_SAVE_ISO: begin
                if (settled) begin
                    next_state = BBS_SAVE;
                end
            end
            BBS_SAVE: begin
                if (!power_switch_sense) begin
                    next_state = BBS_IDLE;
                end else if (ram_done) begin
                    next_state = BBS_ISOLATE;
                end
            end
            BBS_ISOLATE: begin
                if (settled) begin
                    next_state = BBS_DROP;
                end
            end
            BBS_DROP: begin
                // supply stays only while switch held
                if (!power_switch_sense) begin
                    next_state = BBS_DROP;
                end
            end
            default: next_state = BBS_BOOT;
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state <= BBS_BOOT;
        end else begin
            state <= next_state;
        end
    end

    // isolation settle counter
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            settle_cnt <= 4'h0;
        end else if (state != next_state) begin
            settle_cnt <= 4'h0;
        end else if (!settled) begin
            settle_cnt <= settle_cnt + 4'h1;
        end
    end

    // isolation drive: high for access, low before supply loss
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            isolate_drive_port <= 1'b0;
        end else begin
            case (next_state)
                BBS_ARM_ISO, BBS_IDLE, BBS_SAVE_ISO, BBS_SAVE:
                    isolate_drive_port <= 1'b1;
                default: isolate_drive_port <= 1'b0;
            endcase
        end
    end

    // wake request: high from boot on, low only after isolation
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wake_level <= 1'b0;
        end else begin
            case (next_state)
                BBS_ARM_ISO: wake_level <= 1'b1;
                BBS_DROP: wake_level <= 1'b0;
                default: wake_level <= wake_level;
            endcase
        end
    end

    // wake driven from the cycle after boot on, whatever the polarity and arm bits
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wake_oe <= 1'b0;
        end else if (state == BBS_BOOT) begin
            wake_oe <= 1'b1;
        end
    end
    assign wake_out = wake_level;

    // ram write progress
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ram_done <= 1'b0;
        end else if (state != BBS_SAVE) begin
            ram_done <= 1'b0;
        end else if (reg_wr && reg_addr == `BBS_REG_CTRL &&
            reg_wdata[`BBS_CTRL_ARMED_EN]) begin
            ram_done <= 1'b1;
        end
    end

    // control register and ram pointer
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ctrl <= `BBS_CTRL_RESET;
        end else if (reg_wr && reg_addr == `BBS_REG_CTRL) begin
            ctrl <= {reg_wdata[7:3], 1'b0, 1'b1, reg_wdata[0]};
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ram_addr <= '0;
        end else if (reg_wr && reg_addr == `BBS_REG_RAM_ADDR) begin
            ram_addr <= reg_wdata[AW-1:0];
        end else if (ram_wr) begin
            ram_addr <= ram_addr + AW'(1);
        end
    end

    bbs_ret_ram #(
        .DEPTH(DEPTH),
        .AW(AW),
        .DW(DW)
    ) u_ram (
        .sys_clk(sys_clk),
        .wr_en(ram_wr),
        .wr_addr(ram_addr),
        .wr_data(reg_wdata[DW-1:0]),
        .rd_addr(ram_addr),
        .rd_data(ram_rdata)
    );

    // events
    always_comb begin
        ev = '0;
        ev[`BBS_EV_ARMED] = state == BBS_ARM_ISO && next_state == BBS_IDLE;
        ev[`BBS_EV_SWITCH] = state == BBS_IDLE && next_state == BBS_SAVE_ISO;
        ev[`BBS_EV_SAVED] = state == BBS_SAVE && next_state == BBS_ISOLATE;
        ev[`BBS_EV_STANDBY] = state == BBS_ISOLATE && next_state == BBS_DROP;
    end

    assign stat_rd = reg_rd && reg_addr == `BBS_REG_IRQ_STAT;
    assign mask_wr = reg_wr && reg_addr == `BBS_REG_IRQ_MASK;

    bbs_irq #(
        .N(`BBS_EV_NUM)
    ) u_irq (
        .sys_clk(sys_clk),
        .rst(rst),
        .event_set(ev),
        .stat_rd(stat_rd),
        .mask_wr(mask_wr),
        .mask_data(reg_wdata[`BBS_EV_NUM-1:0]),
        .irq_stat(irq_stat),
        .irq_mask(irq_mask),
        .irq(irq)
    );

    // read data, one cycle after strobe
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                `BBS_REG_CTRL: reg_rdata <= ctrl;
                `BBS_REG_STAT: reg_rdata <= {1'b1,
                    power_switch_sense, wake_level, isolate_drive_port,
                    1'b0, state};
                `BBS_REG_IRQ_STAT: reg_rdata <= 8'(irq_stat);
                `BBS_REG_IRQ_MASK: reg_rdata <= 8'(irq_mask);
                `BBS_REG_RAM_ADDR: reg_rdata <= 8'(ram_addr);
                `BBS_REG_RAM_DATA: reg_rdata <= isolate_drive_port ?
                    8'(ram_rdata) : 8'h00;
                default: reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // checks
    AST_ISO_BEFORE_DROP:
    assert property (@(posedge sys_clk) disable iff (rst)
        $fell(wake_level) |->
        !isolate_drive_port && !$past(isolate_drive_port))
    else $error("wake dropped while isolation high");

    AST_RAM_NEEDS_ISO:
    assert property (@(posedge sys_clk) disable iff (rst)
        ram_wr |-> isolate_drive_port)
    else $error("ram written while isolated");

    AST_ARM_WAKE:
    assert property (@(posedge sys_clk) disable iff (rst)
        state == BBS_IDLE |-> wake_level && wake_oe && isolate_drive_port)
    else $error("idle without wake armed");

    AST_BOOT_WAKE:
    assert property (@(posedge sys_clk) disable iff (rst)
        state == BBS_BOOT |=> wake_level)
    else $error("wake not raised at start");

    AST_SWITCH_ISO:
    assert property (@(posedge sys_clk) disable iff (rst)
        state == BBS_IDLE && power_switch_sense && ctrl[`BBS_CTRL_ARM]
        |=> isolate_drive_port && state == BBS_SAVE_ISO)
    else $error("switch did not start save");

    AST_DROP_AFTER_SAVE:
    assert property (@(posedge sys_clk) disable iff (rst)
        $rose(state == BBS_DROP) |-> $past(state) == BBS_ISOLATE)
    else $error("drop without save");

    AST_ISO_LOW_SAVED:
    assert property (@(posedge sys_clk) disable iff (rst)
        state == BBS_SAVE && ram_done && power_switch_sense
        |=> !isolate_drive_port [*2])
    else $error("isolation not lowered after save");

    AST_SWITCH_ABANDON:
    assert property (@(posedge sys_clk) disable iff (rst)
        state == BBS_SAVE && !power_switch_sense |=> state == BBS_IDLE)
    else $error("released switch did not abandon save");

    AST_ISO_MAP:
    assert property (@(posedge sys_clk) disable iff (rst)
        isolate_drive_port == (state inside {BBS_ARM_ISO, BBS_IDLE,
        BBS_SAVE_ISO, BBS_SAVE}))
    else $error("isolation level does not match step");

    AST_ISOLATE_HOLD:
    assert property (@(posedge sys_clk) disable iff (rst)
        $rose(state == BBS_DROP) |-> !$past(isolate_drive_port, 5))
    else $error("isolation not settled before wake drop");

    AST_SAVE_SETTLE:
    assert property (@(posedge sys_clk) disable iff (rst)
        $rose(state == BBS_SAVE) |-> $past(state) == BBS_SAVE_ISO &&
        $past(isolate_drive_port, 5))
    else $error("save entered before isolation settled");

    AST_SAVE_NEEDS_SWITCH:
    assert property (@(posedge sys_clk) disable iff (rst)
        $rose(state == BBS_ISOLATE) |-> $past(power_switch_sense))
    else $error("standby setup finished with switch open");

    AST_RAM_REFUSED:
    assert property (@(posedge sys_clk) disable iff (rst)
        reg_wr && reg_addr == `BBS_REG_RAM_DATA && !isolate_drive_port
        |=> $stable(ram_addr))
    else $error("isolated ram write moved the pointer");

    AST_OE_AFTER_BOOT:
    assert property (@(posedge sys_clk) disable iff (rst)
        state != BBS_BOOT |-> wake_oe)
    else $error("wake pin not driven after start");

    AST_WAKE_HELD:
    assert property (@(posedge sys_clk) disable iff (rst)
        state != BBS_BOOT && state != BBS_DROP |-> wake_level)
    else $error("wake low outside standby");

    AST_ARM_POLARITY:
    assert property (@(posedge sys_clk) disable iff (rst)
        $rose(state == BBS_IDLE) && $past(state) == BBS_ARM_ISO |->
        $past(isolate_drive_port, 5) && ctrl[`BBS_CTRL_WAKE_POL])
    else $error("wake armed before isolation or polarity");
endmodule : bbs_seq

/* File: testbench/bbs_far_side.sv */
`timescale 1ns/1ps

module bbs_far_side #(
    parameter int RTC_TICKS = 20
) (
    // clock
    input wire logic sys_clk,
    // device pins
    input wire logic wake_out,
    input wire logic wake_oe,
    output logic power_switch_sense,
    // scenario controls
    input wire logic press,
    input wire logic rtc_start,
    input wire logic wake_disable,
    // observed regulator output
    output logic supply_on
);
    int ticks;
    logic rtc_wake;
    logic wake_line;

    // switch sense follows the switch level
    assign power_switch_sense = press;

    // rtc raises wake once its interval runs out
    always @(posedge sys_clk) begin
        if (!rtc_start) begin
            ticks <= 0;
            rtc_wake <= 1'b0;
        end else if (ticks == RTC_TICKS) begin
            rtc_wake <= 1'b1;
        end else begin
            ticks <= ticks + 1;
        end
    end

    // released wake line is pulled low at the regulator
    assign wake_line = (wake_oe & wake_out) | rtc_wake;
    // regulator enable: wake or switch, jumper forces on
    assign supply_on = wake_disable | wake_line | press;
endmodule : bbs_far_side

/* File: testbench/battery_backup_standby_sequencer_test.sv */
`timescale 1ns/1ps
`include "bbs_defines.svh"

module battery_backup_standby_sequencer_test
    import bbs_pkg::*;
;
    logic sys_clk, rst, reg_wr, reg_rd, irq, press, rtc_start, wake_disable;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, v;
    logic power_switch_sense, isolate_drive_port, wake_out, wake_oe;
    logic supply_on;
    int mismatches = 0;
    int checks_done = 0;

    bbs_seq i_dut (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .power_switch_sense(power_switch_sense),
        .isolate_drive_port(isolate_drive_port), .wake_out(wake_out),
        .wake_oe(wake_oe), .irq(irq));

    bbs_far_side i_far (.sys_clk(sys_clk), .wake_out(wake_out),
        .wake_oe(wake_oe), .power_switch_sense(power_switch_sense),
        .press(press), .rtc_start(rtc_start),
        .wake_disable(wake_disable), .supply_on(supply_on));

    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        #1;
    endtask : wr

    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : rd

    function automatic logic [7:0] stat(input logic sw, input logic wk,
        input logic iso, input bbs_state_e st);
        return {1'b1, sw, wk, iso, 1'b0, st};
    endfunction : stat

    task automatic power_up();
        @(posedge sys_clk);
        rst <= 1'b1;
        repeat (12) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        #1;
        chk({wake_oe, wake_out, isolate_drive_port}, 8'h07);
        repeat (6) @(posedge sys_clk);
    endtask : power_up

    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : results

    initial begin
        #300000;
        mismatches++;
        results();
    end

    initial begin
        rst = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        press = 1'b0;
        rtc_start = 1'b0;
        wake_disable = 1'b0;
        power_up();
        rd(`BBS_REG_STAT, v);
        chk(v, stat(1'b0, 1'b1, 1'b1, BBS_IDLE));
        rd(`BBS_REG_CTRL, v);
        chk(v, 8'h02);
        rd(4'hF, v);
        chk(v, 8'h00);
        $display("test boot done");

        wr(`BBS_REG_CTRL, 8'h01);
        wr(`BBS_REG_IRQ_MASK, 8'h00);
        chk(irq, 1'b0);
        wr(`BBS_REG_IRQ_MASK, 8'h0F);
        chk(irq, 1'b1);
        rd(`BBS_REG_IRQ_STAT, v);
        chk(v & 8'h01, 8'h01);
        rd(`BBS_REG_IRQ_STAT, v);
        chk(v, 8'h00);
        chk(irq, 1'b0);
        $display("test interrupt done");

        @(posedge sys_clk);
        press <= 1'b1;
        repeat (8) @(posedge sys_clk);
        rd(`BBS_REG_STAT, v);
        chk(v, stat(1'b1, 1'b1, 1'b1, BBS_SAVE));
        @(posedge sys_clk);
        press <= 1'b0;
        repeat (3) @(posedge sys_clk);
        rd(`BBS_REG_STAT, v);
        chk(v, stat(1'b0, 1'b1, 1'b1, BBS_IDLE));
        rd(`BBS_REG_IRQ_STAT, v);
        chk(v & 8'h02, 8'h02);
        $display("test abandoned save done");

        @(posedge sys_clk);
        press <= 1'b1;
        repeat (8) @(posedge sys_clk);
        wr(`BBS_REG_RAM_ADDR, 8'h00);
        for (int i = 0; i < 3; i++) begin
            wr(`BBS_REG_RAM_DATA, 8'hA5 ^ 8'(i));
        end
        wr(`BBS_REG_RAM_ADDR, 8'h01);
        rd(`BBS_REG_RAM_DATA, v);
        chk(v, 8'hA4);
        wr(`BBS_REG_CTRL, 8'h05);
        repeat (3) @(posedge sys_clk);
        #1;
        chk({isolate_drive_port, wake_out}, 8'h01);
        repeat (5) @(posedge sys_clk);
        #1;
        chk({isolate_drive_port, wake_out}, 8'h00);
        chk(supply_on, 1'b1);
        rd(`BBS_REG_RAM_DATA, v);
        chk(v, 8'h00);
        wr(`BBS_REG_RAM_DATA, 8'h5A);
        rd(`BBS_REG_RAM_ADDR, v);
        chk(v, 8'h01);
        rd(`BBS_REG_IRQ_STAT, v);
        chk(v & 8'h0E, 8'h0E);
        @(posedge sys_clk);
        press <= 1'b0;
        @(posedge sys_clk);
        #1;
        chk(supply_on, 1'b0);
        @(posedge sys_clk);
        wake_disable <= 1'b1;
        @(posedge sys_clk);
        #1;
        chk(supply_on, 1'b1);
        @(posedge sys_clk);
        wake_disable <= 1'b0;
        rtc_start <= 1'b1;
        repeat (10) @(posedge sys_clk);
        #1;
        chk(supply_on, 1'b0);
        repeat (15) @(posedge sys_clk);
        #1;
        chk(supply_on, 1'b1);
        @(posedge sys_clk);
        rtc_start <= 1'b0;
        $display("test standby done");

        @(posedge sys_clk);
        press <= 1'b1;
        power_up();
        press <= 1'b0;
        @(posedge sys_clk);
        #1;
        chk(supply_on, 1'b1);
        $display("test switch restart done");
        results();
    end
endmodule : battery_backup_standby_sequencer_test
